/* File: rtl/eip_top.v */
// External interrupt pin front end: edge capture, status and acknowledge
// Behaviour
// - The nonmaskable input is caught on its rising edge, never level.
// - Each external input has its own polarity bit in a 4-bit field.
// - Acknowledge is pulsed for every interrupt the core services.
// - A 4-bit number names the serviced interrupt while ack is high.
// - Numbers follow the service vector order of the fetch packets.
`timescale 1ns/1ps
`include "eip_defines.vh"

module eip_top (
  input  wire                     sys_clk_i,
  input  wire                     rst_b_i,
  input  wire                     nmi_in_i,
  input  wire [`EIP_EXT_N-1:0]    ext_irq_in_i,
  input  wire                     core_svc_i,
  input  wire [3:0]               core_svc_num_i,
  input  wire [`EIP_ADDR_W-1:0]   reg_addr_i,
  input  wire [`EIP_DATA_W-1:0]   reg_wdata_i,
  input  wire                     reg_wr_i,
  input  wire                     reg_rd_i,
  output reg  [`EIP_DATA_W-1:0]   reg_rdata_o,
  output reg                      irq_service_ack_out_o,
  output reg  [3:0]               irq_number_out_o,
  output reg  [`EIP_SRC_N-1:0]    irq_pending_o,
  output reg                      irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [`EIP_EXT_N-1:0] ext_irq_polarity_bits_reg;
  reg  [`EIP_SRC_N-1:0] enable_reg;
  reg  [`EIP_SRC_N-1:0] status_reg;
  reg  [`EIP_SRC_N-1:0] status_next;
  reg  [`EIP_SRC_N-1:0] svc_clr;
  reg  [`EIP_DATA_W-1:0] rdata_next;
  wire [`EIP_SRC_N-1:0] edge_hit;
  wire [`EIP_SRC_N-1:0] sw_clr;
  integer               k;
  wire                  wr_clear;
  wire                  wr_enable;
  wire                  wr_polarity;
  reg  [`EIP_EXT_N-1:0] polarity_next;
  reg  [`EIP_SRC_N-1:0] enable_next;
  reg                   irq_next;
  reg                   ack_next;
  reg  [3:0]            num_next;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection
  eip_edge_det u_nmi_edge (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .sig_i     (nmi_in_i),
    .falling_i (1'b0),
    .edge_o    (edge_hit[`EIP_BIT_NMI])
  );

  genvar g;
  generate
    for (g = 0; g < `EIP_EXT_N; g = g + 1) begin : g_ext
      eip_edge_det u_ext_edge (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .sig_i     (ext_irq_in_i[g]),
        .falling_i (ext_irq_polarity_bits_reg[g]),
        .edge_o    (edge_hit[`EIP_BIT_EXT0+g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  assign wr_clear    = reg_wr_i && (reg_addr_i == `EIP_OFF_CLEAR);
  assign wr_enable   = reg_wr_i && (reg_addr_i == `EIP_OFF_ENABLE);
  assign wr_polarity = reg_wr_i && (reg_addr_i == `EIP_OFF_POLARITY);

  ////////////////////////////////////////////////////////////////////////////
  // Status: set by edge, cleared by software or by servicing; set wins
  assign sw_clr = wr_clear ? reg_wdata_i[`EIP_SRC_N-1:0] :
                  {`EIP_SRC_N{1'b0}};

  always @* begin
    svc_clr = {`EIP_SRC_N{1'b0}};
    if (core_svc_i) begin
      if (core_svc_num_i == `EIP_NUM_NMI)
        svc_clr[`EIP_BIT_NMI] = 1'b1;
      for (k = 0; k < `EIP_EXT_N; k = k + 1) begin
        if (core_svc_num_i == `EIP_NUM_EXT0 + k[3:0])
          svc_clr[`EIP_BIT_EXT0+k] = 1'b1;
      end
    end
    status_next = (status_reg & ~(sw_clr | svc_clr)) | edge_hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  always @* begin
    rdata_next = {`EIP_DATA_W{1'b0}};
    if (reg_rd_i) begin
      case (reg_addr_i)
        `EIP_OFF_STATUS:
          rdata_next[`EIP_SRC_N-1:0] = status_reg;
        `EIP_OFF_ENABLE:
          rdata_next[`EIP_SRC_N-1:0] = enable_reg;
        `EIP_OFF_POLARITY:
          rdata_next[`EIP_EXT_N-1:0] = ext_irq_polarity_bits_reg;
        default:
          rdata_next = {`EIP_DATA_W{1'b0}};
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next values of the control and pin registers
  always @* begin
    polarity_next = ext_irq_polarity_bits_reg;
    if (wr_polarity)
      polarity_next = reg_wdata_i[`EIP_EXT_N-1:0];
  end

  always @* begin
    enable_next = enable_reg;
    if (wr_enable)
      enable_next = reg_wdata_i[`EIP_SRC_N-1:0];
  end

  // Taken from the next status so irq_o and irq_pending_o move together
  always @* begin
    irq_next = |(status_next & enable_reg);
  end

  // Number held between services so it stays valid beside the ack
  always @* begin
    ack_next = core_svc_i;
    num_next = irq_number_out_o;
    if (core_svc_i)
      num_next = core_svc_num_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ext_irq_polarity_bits_reg <= `EIP_RST_POLARITY;
      enable_reg                <= `EIP_RST_ENABLE;
    end else begin
      ext_irq_polarity_bits_reg <= polarity_next;
      enable_reg                <= enable_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and the level outputs
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      status_reg    <= `EIP_RST_STATUS;
      irq_pending_o <= `EIP_RST_STATUS;
      irq_o         <= 1'b0;
    end else begin
      status_reg    <= status_next;
      irq_pending_o <= status_next;
      irq_o         <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data stands for one cycle, zero otherwise
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= {`EIP_DATA_W{1'b0}};
    end else begin
      reg_rdata_o <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Service acknowledge and number
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      irq_service_ack_out_o <= 1'b0;
      irq_number_out_o      <= `EIP_RST_NUM;
    end else begin
      irq_service_ack_out_o <= ack_next;
      irq_number_out_o      <= num_next;
    end
  end

endmodule // eip_top

/* File: rtl/eip_defines.vh */
// Constants for the external interrupt pin front end
`ifndef EIP_DEFINES_VH
`define EIP_DEFINES_VH

`define EIP_ADDR_W        4
`define EIP_DATA_W        32
`define EIP_EXT_N         4
`define EIP_SRC_N         5

// Register byte offsets
`define EIP_OFF_STATUS    4'h0
`define EIP_OFF_CLEAR     4'h4
`define EIP_OFF_ENABLE    4'h8
`define EIP_OFF_POLARITY  4'hC

// Source bit positions in status, clear and enable
`define EIP_BIT_NMI       0
`define EIP_BIT_EXT0      1

// Reset values
`define EIP_RST_POLARITY  4'h0
`define EIP_RST_ENABLE    5'h00
`define EIP_RST_STATUS    5'h00
`define EIP_RST_NUM       4'h0

// Interrupt numbers in service vector order
`define EIP_NUM_NMI       4'h1
`define EIP_NUM_EXT0      4'h4

`endif

/* File: rtl/eip_edge_det.v */
// Single-input edge detector with selectable active edge
`timescale 1ns/1ps
`include "eip_defines.vh"

module eip_edge_det (
  input  wire sys_clk_i,
  input  wire rst_b_i,
  input  wire sig_i,
  input  wire falling_i,
  output wire edge_o
);

  reg prev_reg;
  reg armed_reg;
  wire lvl;

  // Falling edge is a rising edge of the inverted input
  assign lvl = sig_i ^ falling_i;

  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      prev_reg  <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      prev_reg  <= lvl;
      armed_reg <= 1'b1;
    end
  end

  // No edge in the first cycle after reset: prev is not yet a real sample
  assign edge_o = armed_reg & lvl & ~prev_reg;

endmodule // eip_edge_det

/* File: sim/eip_src_model.sv */
// Behavioural interrupt sources facing the pin front end
`timescale 1ns/1ps
module eip_src_model (
  input  wire       sys_clk_i,
  input  wire [4:0] lvl_i,
  output reg        nmi_o = 1'b0,
  output reg  [3:0] ext_o = 4'h0
);
  // Pins move just after the clock edge, like board logic would
  always @(posedge sys_clk_i) begin
    nmi_o <= lvl_i[0];
    ext_o <= lvl_i[4:1];
  end
endmodule // eip_src_model

/* File: sim/eip_checker.sv */
// Port assertions for the pin front end
`timescale 1ns/1ps
`include "eip_defines.vh"
module eip_checker (
  input wire        sys_clk_i,
  input wire        rst_b_i,
  input wire        nmi_in_i,
  input wire        core_svc_i,
  input wire [3:0]  core_svc_num_i,
  input wire        reg_wr_i,
  input wire [3:0]  reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire        irq_service_ack_out_o,
  input wire [3:0]  irq_number_out_o,
  input wire [4:0]  irq_pending_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_nmi_rise;
    rst_b_i ##1 !nmi_in_i ##1 nmi_in_i;
  endsequence
  a_nmi_edge_set: assert property (s_nmi_rise |=>
    irq_pending_o[0]) else $error("nmi edge not captured");
  a_nmi_no_level: assert property ($rose(irq_pending_o[0]) |->
    $past(nmi_in_i) && !$past(nmi_in_i, 2)) else $error("nmi set w/o edge");
  a_nmi_sticky: assert property ($fell(irq_pending_o[0]) |->
    ($past(reg_wr_i) && $past(reg_addr_i) == `EIP_OFF_CLEAR &&
     $past(reg_wdata_i[`EIP_BIT_NMI])) ||
    ($past(core_svc_i) && $past(core_svc_num_i) == `EIP_NUM_NMI))
    else $error("nmi status lost");
  a_ack_follows: assert property (core_svc_i |=>
    irq_service_ack_out_o && irq_number_out_o == $past(core_svc_num_i))
    else $error("ack or number wrong");
  a_ack_cause: assert property (irq_service_ack_out_o |->
    $past(core_svc_i)) else $error("ack without service");
  a_num_hold: assert property (!irq_service_ack_out_o |->
    $stable(irq_number_out_o)) else $error("number moved");
endmodule // eip_checker
bind eip_top eip_checker chk_u (.*);

/* File: sim/eip_top_tb.sv */
// Self-checking bench for the pin front end
`timescale 1ns/1ps
`include "eip_defines.vh"
module eip_top_tb;
  reg         sys_clk_i = 1'b0, rst_b_i = 1'b0, core_svc_i = 1'b0;
  reg         reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  reg  [3:0]  core_svc_num_i = 4'h0, reg_addr_i = 4'h0;
  reg  [31:0] reg_wdata_i = 32'h0;
  reg  [4:0]  lvl = 5'h00;
  wire        nmi_in_i, irq_service_ack_out_o, irq_o;
  wire [3:0]  ext_irq_in_i, irq_number_out_o;
  wire [31:0] reg_rdata_o;
  wire [4:0]  irq_pending_o;
  integer     num_errors = 0, samples_checked = 0, i;
  always #2.5 sys_clk_i = ~sys_clk_i;
  eip_src_model src_u (.sys_clk_i(sys_clk_i), .lvl_i(lvl), .nmi_o(nmi_in_i),
                       .ext_o(ext_irq_in_i));
  eip_top dut_u (.*);
  task chk(input [39:0] n, input [31:0] e, input [31:0] g); begin
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("ERROR %0s exp %0h got %0h", n, e, g);
    end
  end endtask
  task wr(input [3:0] a, input [31:0] d); begin
    @(posedge sys_clk_i); reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1;
    @(posedge sys_clk_i); reg_wr_i <= 1'b0;
  end endtask
  task rd(input [3:0] a, input [31:0] e); begin
    @(posedge sys_clk_i); reg_addr_i <= a; reg_rd_i <= 1'b1;
    @(posedge sys_clk_i); reg_rd_i <= 1'b0;
    #1 chk("rdata", e, reg_rdata_o);
  end endtask
  task svc(input [3:0] n); begin
    @(posedge sys_clk_i); core_svc_num_i <= n; core_svc_i <= 1'b1;
    @(posedge sys_clk_i); core_svc_i <= 1'b0;
    #1 chk("ack", 1, irq_service_ack_out_o);
    chk("num", n, irq_number_out_o);
  end endtask
  task pins(input [4:0] v); begin
    @(posedge sys_clk_i); lvl <= v;
    repeat (4) @(posedge sys_clk_i);
    #1;
  end endtask
  task test_done; begin
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  end endtask
  initial begin
    #20000 num_errors = num_errors + 1;
    test_done;
  end
  initial begin
    repeat (2) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    rd(`EIP_OFF_STATUS, 32'h0);
    wr(`EIP_OFF_ENABLE, 32'h1F);
    rd(`EIP_OFF_ENABLE, 32'h1F);
    pins(5'h01);
    chk("pend", 1, irq_pending_o);
    chk("irq", 1, irq_o);
    svc(`EIP_NUM_NMI);
    pins(5'h01);
    chk("pend", 0, irq_pending_o);
    // Falling idle is high: park inputs there before clearing
    wr(`EIP_OFF_POLARITY, 32'hA);
    rd(`EIP_OFF_POLARITY, 32'hA);
    pins(5'h14);
    chk("pend", 5'h14, irq_pending_o);
    wr(`EIP_OFF_CLEAR, 32'h1F);
    rd(`EIP_OFF_CLEAR, 32'h0);
    rd(4'h2, 32'h0);
    pins(5'h0A);
    chk("pend", 5'h1E, irq_pending_o);
    wr(`EIP_OFF_ENABLE, 32'h0);
    rd(`EIP_OFF_STATUS, 32'h1E);
    chk("irq", 0, irq_o);
    for (i = 0; i < 4; i = i + 1) begin
      svc(`EIP_NUM_EXT0 + i[3:0]);
      rd(`EIP_OFF_STATUS, 32'h1E & ~((32'h1 << (i + 2)) - 32'h2));
    end
    svc(4'hD);
    test_done;
  end
endmodule // eip_top_tb
